// ### rtl/ext_pin_sync.sv
// two-stage synchroniser for the external count clock pin
module ext_pin_sync (
   input  wire logic core_clk_i, // core clock
   input  wire logic rst_n_i,    // synchronous reset, active low
   input  wire logic ce_i,       // clock enable, freezes stages
   input  wire logic pin_i,      // asynchronous pin level
   output logic      sync_o      // level after two flops
);

   logic meta;

   // first flop feeds only the second one
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         meta   <= 1'b0;
         sync_o <= 1'b0;
      end else if (ce_i) begin
         meta   <= pin_i;
         sync_o <= meta;
      end
   end

endmodule

// ### rtl/timer_one_core.sv
// 16-bit timer/counter with prescaler, wide access and overflow interrupt
module timer_one_core (
   input  wire logic                    core_clk_i,       // core clock, 20 MHz
   input  wire logic                    rst_n_i,          // synchronous reset, active low
   input  wire logic                    ce_i,             // clock enable, low freezes all state
   input  wire timer_one_pkg::avs_req_t bus_req_i,        // avalon-mm request
   output timer_one_pkg::avs_rsp_t      bus_rsp_o,        // avalon-mm answer
   input  wire logic                    ext_clk_i,        // external clock pin or oscillator
   input  wire logic                    special_event_i,  // compare unit trigger, same clock
   output logic                         irq_o,            // level interrupt
   output logic                         crystal_osc_en_o, // runs the crystal oscillator
   output logic [15:0]                  count_o           // live count
);
   import timer_one_pkg::*;

   timer_state_t st;
   timer_state_t nx;
   logic         ext_sync;
   logic         ext_edge;
   logic         accept;
   logic         rd;
   logic         wr;
   logic         wr_low;
   logic         wr_high;
   logic         trig_take;
   logic         advance;
   logic         psc_last;
   logic         inc;
   logic         overflow;
   logic         flag_clear;
   logic [PSC_W-1:0] psc_limit;
   logic [31:0]  read_value;

   ext_pin_sync u_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .ce_i       (ce_i),
      .pin_i      (ext_clk_i),
      .sync_o     (ext_sync)
   );

   // the unsynchronised path takes the edge one cycle earlier than the
   // phase-aligned path; a true clockless path is not possible on one clock
   assign ext_edge = st.ctrl.ext_sync_disable ? (ext_sync & ~st.ext_d1)
                                              : (st.ext_d1 & ~st.ext_d2);

   // bus decode: a request is taken once, while waitrequest is still high
   assign accept  = (bus_req_i.read | bus_req_i.write) & st.rsp.waitrequest;
   assign rd      = accept & bus_req_i.read;
   assign wr      = accept & bus_req_i.write;
   assign wr_low  = wr & (bus_req_i.address == ADDR_COUNT_LOW);
   assign wr_high = wr & (bus_req_i.address == ADDR_COUNT_HIGH);
   assign flag_clear = wr & (bus_req_i.address == ADDR_IRQ_CLEAR) & bus_req_i.writedata[BIT_OVERFLOW];

   // trigger is unreliable on an asynchronous external count, so it is
   // ignored there; a count write wins over a coinciding trigger
   assign trig_take = special_event_i & ~wr_low & ~wr_high
                      & ~(st.ctrl.count_source_select & st.ctrl.ext_sync_disable);

   // internal source counts every cycle, external only on rising edges
   assign advance = st.ctrl.count_run_enable
                    & (st.ctrl.count_source_select ? ext_edge : 1'b1);

   // prescale ratio 2^select, so the last phase is ratio minus one
   always_comb begin
      case (st.ctrl.input_prescale_select)
         2'b00:   psc_limit = 3'h0;
         2'b01:   psc_limit = 3'h1;
         2'b10:   psc_limit = 3'h3;
         default: psc_limit = 3'h7;
      endcase
   end
   // at or above the limit, so a ratio lowered mid-run cannot strand the phase
   assign psc_last = (st.psc >= psc_limit);
   assign inc      = advance & psc_last;
   assign overflow = inc & (st.count == COUNT_MAX) & ~trig_take & ~wr_low;

   // register read multiplexer; unmapped and write-only words read as zero
   always_comb begin
      read_value = 32'h0000_0000;
      case (bus_req_i.address)
         ADDR_CONTROL:    read_value[7:0] = st.ctrl & CONTROL_WMASK;
         ADDR_COUNT_LOW:  read_value[7:0] = st.count[7:0];
         ADDR_COUNT_HIGH: read_value[7:0] = st.ctrl.wide_access_enable ? st.high_buf
                                                                       : st.count[15:8];
         ADDR_IRQ_STATUS: read_value[BIT_OVERFLOW] = st.overflow_flag;
         ADDR_IRQ_ENABLE: read_value[BIT_OVERFLOW] = st.overflow_irq_enable;
         default:         read_value = 32'h0000_0000;
      endcase
   end

   // next state: count, prescaler, registers, interrupt and bus answer
   always_comb begin
      nx = st;
      nx.ext_d1 = ext_sync;
      nx.ext_d2 = st.ext_d1;
      nx.rsp.waitrequest = 1'b1;

      if (advance) begin
         nx.psc = psc_last ? '0 : PSC_W'(st.psc + 1'b1);
      end
      if (inc) begin
         nx.count = 16'(st.count + 1'b1);
      end
      if (trig_take) begin
         nx.count = COUNT_RESET;
         nx.psc   = '0;
      end

      // software writes take precedence over counting
      if (wr) begin
         case (bus_req_i.address)
            ADDR_CONTROL: begin
               nx.ctrl = control_t'(bus_req_i.writedata[7:0] & CONTROL_WMASK);
            end
            ADDR_COUNT_LOW: begin
               nx.count[7:0] = bus_req_i.writedata[7:0];
               nx.psc        = '0;
               if (st.ctrl.wide_access_enable) begin
                  nx.count[15:8] = st.high_buf;
               end
            end
            ADDR_COUNT_HIGH: begin
               if (st.ctrl.wide_access_enable) begin
                  nx.high_buf = bus_req_i.writedata[7:0];
               end else begin
                  nx.count[15:8] = bus_req_i.writedata[7:0];
               end
            end
            ADDR_IRQ_ENABLE: begin
               nx.overflow_irq_enable = bus_req_i.writedata[BIT_OVERFLOW];
            end
            default: begin
            end
         endcase
      end

      // a low byte read snapshots the high byte for a coherent pair
      if (rd && bus_req_i.address == ADDR_COUNT_LOW && st.ctrl.wide_access_enable) begin
         nx.high_buf = st.count[15:8];
      end

      // sticky flag: an overflow in the clearing cycle is kept
      nx.overflow_flag = (st.overflow_flag & ~flag_clear) | overflow;
      nx.irq           = nx.overflow_flag & nx.overflow_irq_enable;

      if (accept) begin
         nx.rsp.waitrequest = 1'b0;
         nx.rsp.readdata    = rd ? read_value : 32'h0000_0000;
      end
   end

   // single state register, frozen while the clock enable is low
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st <= STATE_RESET;
      end else if (ce_i) begin
         st <= nx;
      end
   end

   // outputs straight from the state register
   assign bus_rsp_o        = st.rsp;
   assign irq_o            = st.irq;
   assign crystal_osc_en_o = st.ctrl.crystal_osc_enable;
   assign count_o          = st.count;

   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_control_read_zero: assert property (
      ce_i && rd && bus_req_i.address == ADDR_CONTROL
      |=> bus_rsp_o.readdata[6] == 1'b0 && bus_rsp_o.readdata[31:8] == 24'h000000 && !bus_rsp_o.waitrequest)
      else $error("control read shows reserved bits");

   a_wrap_to_zero: assert property (
      ce_i && inc && st.count == COUNT_MAX && !trig_take && !wr_low && !wr_high
      |=> count_o == COUNT_RESET && st.overflow_flag)
      else $error("wrap did not give zero with flag");

   a_stopped_holds: assert property (
      ce_i && !st.ctrl.count_run_enable && !wr && !trig_take
      |=> count_o == $past(count_o))
      else $error("count moved while stopped");

   a_internal_steps: assert property (
      ce_i && st.ctrl.count_run_enable && !st.ctrl.count_source_select
      && st.ctrl.input_prescale_select == 2'b00 && !wr && !trig_take
      |=> count_o == 16'($past(count_o) + 1'b1))
      else $error("internal clock did not step count");

   a_prescale_eight: assert property (
      ce_i && inc && st.ctrl.input_prescale_select == 2'b11 |-> st.psc == 3'h7)
      else $error("1:8 prescale stepped early");

   a_trigger_clears: assert property (
      ce_i && special_event_i && !wr && !st.ctrl.count_source_select
      |=> count_o == COUNT_RESET)
      else $error("trigger did not clear count");

   a_wide_snapshot: assert property (
      ce_i && rd && bus_req_i.address == ADDR_COUNT_LOW && st.ctrl.wide_access_enable
      |=> st.high_buf == $past(count_o[15:8]))
      else $error("low read did not snapshot high byte");

   a_wide_load: assert property (
      ce_i && wr_low && st.ctrl.wide_access_enable
      |=> count_o == {$past(st.high_buf), $past(bus_req_i.writedata[7:0])})
      else $error("low write did not load both bytes");

   a_wide_high_map: assert property (
      ce_i && wr_high && st.ctrl.wide_access_enable
      |=> st.high_buf == $past(bus_req_i.writedata[7:0]))
      else $error("high write missed the buffer");

   a_ext_async_edge: assert property (
      ce_i && st.ctrl.count_run_enable && st.ctrl.count_source_select
      && st.ctrl.ext_sync_disable && st.ctrl.input_prescale_select == 2'b00
      && ext_sync && !st.ext_d1 && !wr
      |=> count_o == 16'($past(count_o) + 1'b1))
      else $error("external edge not counted");

   a_osc_follows: assert property (
      ce_i && wr && bus_req_i.address == ADDR_CONTROL
      |=> crystal_osc_en_o == $past(bus_req_i.writedata[BIT_OSC]))
      else $error("oscillator enable not taken");

   a_flag_sticky: assert property (
      ce_i && st.overflow_flag && !flag_clear |=> st.overflow_flag)
      else $error("flag dropped without clear");

   a_irq_gated: assert property (
      irq_o == (st.overflow_flag && st.overflow_irq_enable))
      else $error("interrupt does not match flag and enable");

   a_answer_once: assert property (
      ce_i && accept |=> !bus_rsp_o.waitrequest ##1 bus_rsp_o.waitrequest)
      else $error("answer not a single cycle");

   c_overflow: cover property (ce_i && overflow);
   c_trigger:  cover property (ce_i && trig_take && st.ctrl.count_run_enable);
   c_wide_rd:  cover property (ce_i && rd && bus_req_i.address == ADDR_COUNT_LOW && st.ctrl.wide_access_enable);
   c_irq:      cover property (irq_o ##1 !irq_o);

endmodule

// ### rtl/timer_one_pkg.sv
// constants, register map and carrier types of the 16-bit timer/counter
// Functional notes
// - count is 16 bits held as readable, writable low and high byte registers
// - overflow event when count wraps from FFFF to 0000; counting carries on
// - compare unit special event trigger resets the count (here ignored on an external source with bit 2 set)
// - control bits 5:4 pick prescale 1:1, 1:2, 1:4 or 1:8
// - control bit 3 runs the crystal oscillator; clear shuts it off
// - external source: bit 2 set skips synchronisation, clear synchronises first (here the pin still passes both flops; bit 2 only saves a cycle)
// - internal source ignores bit 2 and counts the internal clock
// - control bit 1 picks external rising edges, else internal clock
// - counting only while control bit 0 is set
// - wide access bit 7 maps the high byte address onto a buffer
// - wide mode: low byte read copies live high byte into the buffer
// - wide mode: low byte write loads high byte from buffer together
// - overflow latches a sticky flag; interrupt only when enabled
package timer_one_pkg;

   // byte addresses on the register bus
   localparam logic [7:0] ADDR_CONTROL    = 8'h00;
   localparam logic [7:0] ADDR_COUNT_LOW  = 8'h04;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;

   // field positions and reset values
   localparam int         BIT_OSC         = 3;
   localparam int         BIT_OVERFLOW    = 0;
   localparam logic [7:0] CONTROL_WMASK   = 8'hBF;
   localparam logic [7:0] CONTROL_RESET   = 8'h00;
   localparam logic [15:0] COUNT_RESET    = 16'h0000;
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
   localparam int         PSC_W           = 3;

   // control register layout, msb first
   typedef struct packed {
      logic       wide_access_enable;
      logic       unused;
      logic [1:0] input_prescale_select;
      logic       crystal_osc_enable;
      logic       ext_sync_disable;
      logic       count_source_select;
      logic       count_run_enable;
   } control_t;

   // avalon-mm request from the master
   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
   } avs_req_t;

   // avalon-mm answer to the master
   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } avs_rsp_t;

   // whole state of the timer core except the two pin synchroniser flops
   typedef struct packed {
      control_t         ctrl;
      logic [15:0]      count;
      logic [7:0]       high_buf;
      logic [PSC_W-1:0] psc;
      logic             ext_d1;
      logic             ext_d2;
      logic             overflow_flag;
      logic             overflow_irq_enable;
      logic             irq;
      avs_rsp_t         rsp;
   } timer_state_t;

   localparam timer_state_t STATE_RESET = '{
      ctrl    : control_t'(CONTROL_RESET),
      count   : COUNT_RESET,
      rsp     : '{waitrequest: 1'b1, readdata: 32'h0000_0000},
      default : '0
   };

endpackage

// ### sim/ext_clock_src.sv
// model of the external clock source or watch crystal at the count pin
module ext_clock_src #(
   parameter int HALF_NS = 175 // half period, slow; seven half periods of the 20 MHz core clock
) (
   output logic ext_clk_o // count pin level
);
   timeunit 1ns;
   timeprecision 1ps;

   // the pin rests low between bursts, so no stray rising edge is ever counted
   initial ext_clk_o = 1'b0;

   // n rising edges, each level held for one half period
   task automatic burst(input int n);
      for (int k = 0; k < n; k++) begin
         #(HALF_NS) ext_clk_o = 1'b1;
         #(HALF_NS) ext_clk_o = 1'b0;
      end
   endtask
endmodule

// ### sim/sixteen_bit_timer_counter_one_tb.sv
// self-checking testbench of the 16-bit timer/counter
module sixteen_bit_timer_counter_one_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_one_pkg::*;

   logic        core_clk;
   logic        rst_n;
   logic        ce;
   avs_req_t    bus_req;
   avs_rsp_t    bus_rsp;
   logic        ext_clk;
   logic        special_event;
   logic        irq;
   logic        osc_en;
   logic [15:0] count;
   logic [15:0] held;
   logic [31:0] rdata;
   int          fail_count;
   int          checks;
   int          r;

   // 20 MHz core clock
   always #25 core_clk = ~core_clk;

   timer_one_core i_timer_one_core (
      .core_clk_i(core_clk), .rst_n_i(rst_n), .ce_i(ce),
      .bus_req_i(bus_req), .bus_rsp_o(bus_rsp), .ext_clk_i(ext_clk),
      .special_event_i(special_event), .irq_o(irq), .crystal_osc_en_o(osc_en),
      .count_o(count)
   );

   ext_clock_src #(.HALF_NS(175)) i_ext_clock_src (
      .ext_clk_o(ext_clk)
   );

   // one comparison, counted; a mismatch is reported at once
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // verdict and end of run, also reached when a wait runs out
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // one avalon-mm transfer; request held until waitrequest is seen low
   task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      int n;
      n = 0;
      @(posedge core_clk);
      bus_req <= '{read: !wr, write: wr, address: addr, writedata: wdata};
      do begin
         @(posedge core_clk);
         n++;
      end while (bus_rsp.waitrequest !== 1'b0 && n < 50);
      rdata = bus_rsp.readdata;
      bus_req <= '0;
      if (n >= 50) begin
         chk("bus answer", 32'h1, 32'h0);
         complete_run();
      end
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] d);
      access(1'b1, addr, {24'h000000, d});
   endtask

   task automatic rd(input string name, input logic [7:0] addr, input logic [31:0] exp);
      access(1'b0, addr, 32'h00000000);
      chk(name, exp, rdata);
   endtask

   // the interrupt is registered behind its causes, so let two edges land first
   task automatic irq_is(input logic e);
      repeat (2) @(posedge core_clk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask

   // number of edges between two successive steps of the live count
   task automatic step_gap(output int gap);
      logic [15:0] last;
      int          n;
      n = 0;
      last = count;
      while (count === last && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      last = count;
      gap = 0;
      while (count === last && gap < 100) begin
         @(posedge core_clk);
         gap++;
      end
      if (n >= 100 || gap >= 100) begin
         chk("count step", 32'h1, 32'h0);
         complete_run();
      end
   endtask

   // main sequence
   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      bus_req = '0;
      special_event = 1'b0;
      fail_count = 0;
      checks = 0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rd("control", ADDR_CONTROL, 32'h00000000);
      chk("count", 32'h00000000, {16'h0000, count});
      rd("status", ADDR_IRQ_STATUS, 32'h00000000);
      rd("unmapped", 8'h20, 32'h00000000);
      rd("clear reg", ADDR_IRQ_CLEAR, 32'h00000000);
      chk("osc enable", 32'h0, {31'h0, osc_en});
      $display("test reset done");
      wr(ADDR_CONTROL, 8'hFF);
      rd("control", ADDR_CONTROL, 32'h000000BF);
      chk("osc enable", 32'h1, {31'h0, osc_en});
      wr(ADDR_CONTROL, 8'h00);
      @(posedge core_clk);
      chk("osc enable", 32'h0, {31'h0, osc_en});
      $display("test control done");
      // every prescale code, sync bit toggled on the internal source
      for (int p = 0; p < 4; p++) begin
         wr(ADDR_CONTROL, {2'b00, p[1:0], 1'b0, p[0], 2'b01});
         step_gap(r);
         chk("prescale gap", 32'h1 << p, 32'(r));
      end
      wr(ADDR_CONTROL, 8'h00);
      held = count;
      repeat (20) @(posedge core_clk);
      chk("stopped count", {16'h0000, held}, {16'h0000, count});
      $display("test prescale done");
      wr(ADDR_COUNT_HIGH, 8'h56);
      wr(ADDR_COUNT_LOW, 8'h9A);
      chk("count", 32'h0000569A, {16'h0000, count});
      rd("high byte", ADDR_COUNT_HIGH, 32'h00000056);
      wr(ADDR_CONTROL, 8'h80);
      wr(ADDR_COUNT_HIGH, 8'h12);
      chk("count", 32'h0000569A, {16'h0000, count});
      wr(ADDR_COUNT_LOW, 8'h34);
      chk("count", 32'h00001234, {16'h0000, count});
      wr(ADDR_COUNT_HIGH, 8'hEE);
      rd("low byte", ADDR_COUNT_LOW, 32'h00000034);
      rd("buffer", ADDR_COUNT_HIGH, 32'h00000012);
      $display("test byte access done");
      wr(ADDR_COUNT_HIGH, 8'hFF);
      wr(ADDR_COUNT_LOW, 8'hFE);
      wr(ADDR_IRQ_ENABLE, 8'h01);
      wr(ADDR_CONTROL, 8'h81);
      for (int n = 0; n < 50 && irq !== 1'b1; n++) begin
         @(posedge core_clk);
      end
      chk("irq", 32'h1, {31'h0, irq});
      if (irq !== 1'b1) begin
         complete_run();
      end
      chk("wrapped", 32'h1, {31'h0, count < 16'h0010});
      rd("status", ADDR_IRQ_STATUS, 32'h00000001);
      wr(ADDR_IRQ_ENABLE, 8'h00);
      irq_is(1'b0);
      rd("status", ADDR_IRQ_STATUS, 32'h00000001);
      wr(ADDR_IRQ_ENABLE, 8'h01);
      irq_is(1'b1);
      wr(ADDR_IRQ_CLEAR, 8'h01);
      irq_is(1'b0);
      rd("status", ADDR_IRQ_STATUS, 32'h00000000);
      $display("test overflow done");
      repeat (40) @(posedge core_clk);
      special_event <= 1'b1;
      @(posedge core_clk);
      special_event <= 1'b0;
      @(posedge core_clk);
      chk("cleared by trigger", 32'h00000000, {16'h0000, count});
      $display("test trigger done");
      // clock enable low must freeze the running count
      ce <= 1'b0;
      @(posedge core_clk);
      held = count;
      repeat (10) @(posedge core_clk);
      chk("frozen count", {16'h0000, held}, {16'h0000, count});
      ce <= 1'b1;
      $display("test clock enable done");
      wr(ADDR_CONTROL, 8'h80);
      wr(ADDR_COUNT_HIGH, 8'h00);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_CONTROL, 8'h83);
      i_ext_clock_src.burst(5);
      repeat (8) @(posedge core_clk);
      chk("sync pin count", 32'h00000005, {16'h0000, count});
      wr(ADDR_CONTROL, 8'h87);
      i_ext_clock_src.burst(3);
      repeat (8) @(posedge core_clk);
      chk("async pin count", 32'h00000008, {16'h0000, count});
      $display("test external source done");
      complete_run();
   end
endmodule
